// [bench/crcsr_reader.sv]
// model of the user logic that clocks the signature out serially
`timescale 1ns/10ps
module crcsr_reader
(
  input wire logic clk_in,
  input wire logic regout_in,
  output crcsr_pkg::crcsr_rd_t rd_out
);
  import crcsr_pkg::*;
  initial rd_out = '0;
  // ==========
  // load then 31 shifts; slow stretches both phases
  task automatic read_word(input logic src, input int slow, output logic [31:0] w);
    for (int i = 0; i < 32; i++)
    begin
      @(posedge clk_in);
      rd_out <= '{1'b0, i != 0, src ^ (i != 0)};
      repeat (slow) @(posedge clk_in);
      @(posedge clk_in);
      rd_out.rclk <= 1'b1;
      repeat (slow + 2) @(posedge clk_in);
      w[i] = regout_in;
    end
  endtask
endmodule

// [bench/crcsr_sva.sv]
// assertion checker for the crc signature readout port
`timescale 1ns/10ps
module crcsr_sva
#(
  parameter bit FORCE_OD = 1'b0
)
(
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [7:0] paddr_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire crcsr_pkg::crcsr_rd_t rd_in,
  input wire logic regout_out,
  input wire logic crc_fault_out,
  input wire crcsr_pkg::crcsr_pin_t fault_pin_out,
  input wire logic cycle_done_out
);
  import crcsr_pkg::*;
  // ==========
  // one domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_no_rise;
    !rd_in.rclk || $past(rd_in.rclk);
  endsequence
  a_pready_next: assert property (s_setup |=> pready_out)
    else $error("no answer after setup");
  a_pready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready held too long");
  a_err_unmapped: assert property (s_setup ##0 paddr_in > SIG_OFS |=> pslverr_out)
    else $error("unmapped access not refused");
  a_ok_mapped: assert property (s_setup ##0 paddr_in == SIG_OFS |=> !pslverr_out)
    else $error("mapped access refused");
  a_regout_hold: assert property (s_no_rise |=> $stable(regout_out))
    else $error("serial bit moved without readout edge");
  a_done_gap: assert property (cycle_done_out |=> !cycle_done_out [*8])
    else $error("completion pulse too wide");
  a_fault_at_end: assert property (FORCE_OD && $rose(crc_fault_out) |-> cycle_done_out)
    else $error("fault rose outside pass end");
  a_od_release: assert property (FORCE_OD && crc_fault_out |-> fault_pin_out.oe_b)
    else $error("open drain pin driven during fault");
  a_od_low: assert property (FORCE_OD && !fault_pin_out.oe_b |-> !fault_pin_out.drv)
    else $error("open drain pin driven high");
endmodule
bind crcsr_top crcsr_sva #(.FORCE_OD(FORCE_OD)) i_sva (.sys_clk_in, .rst_b_in, .psel_in,
  .penable_in, .paddr_in, .pready_out, .pslverr_out, .rd_in, .regout_out, .crc_fault_out,
  .fault_pin_out, .cycle_done_out);

// [bench/testbench.sv]
// self-checking bench for the crc signature readout port
`timescale 1ns/10ps
module testbench;
  import crcsr_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] comp = 32'h0;
  logic [31:0] prd, q, pre, bad;
  logic prdy, perr, er, rgo, flt, done;
  logic [3:0] dv [3] = '{4'h0, 4'h3, 4'h8};
  crcsr_rd_t rd;
  crcsr_pin_t pin;
  int fails = 0;
  int comparisons = 0;
  int seed = 42;
  int n;
  crcsr_top #(.FORCE_OD(1'b1)) i_dut (.sys_clk_in(clk), .rst_b_in(rst_b), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(prdy), .pslverr_out(perr), .rd_in(rd), .computed_crc_in(comp),
    .regout_out(rgo), .crc_fault_out(flt), .fault_pin_out(pin), .cycle_done_out(done));
  crcsr_reader i_rd (.clk_in(clk), .regout_in(rgo), .rd_out(rd));
  // ==========
  initial forever #20 clk = ~clk;
  function automatic logic [31:0] sig_of(input logic [31:0] p, input logic [31:0] c);
    return p ^ c;
  endfunction
  function automatic int period_of(input logic [3:0] d);
    return int'(PASS_TICKS) << d;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // setup, then access until pready; the watchdog bounds the wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    q = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wait_done(output int c);
    c = 0;
    do
    begin
      @(posedge clk);
      c++;
    end while (done !== 1'b1);
  endtask
  task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========
  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(q, 32'h20);
    apb(1'b0, SIG_OFS, 32'h0);
    chk(q, SIG_RST);
    apb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0);
    chk(32'(er), 32'h1);
    $display("test reset and refusal done");
    for (int k = 0; k < 3; k++)
    begin
      pre = $random(seed);
      apb(1'b1, PRECRC_OFS, pre);
      i_rd.read_word(1'b0, k, q);
      chk(q, pre);
    end
    $display("test precomputed readout done");
    bad = $random(seed) | 32'h1;
    // clean pass, faulty passes, then clean again, each at its own divisor
    for (int k = 0; k < 3; k++)
    begin
      comp <= (k == 1) ? (pre ^ bad) : pre;
      apb(1'b1, CTRL_OFS, {26'h0, 1'b0, dv[k], 1'b1});
      wait_done(n);
      wait_done(n);
      chk(n, period_of(dv[k]));
      chk(32'(flt), 32'(k == 1));
      chk(32'(pin.oe_b), 32'(k == 1));
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(32'(q[1:0]), {30'h0, 1'b1, k == 1});
      i_rd.read_word(1'b1, k, q);
      chk(q, sig_of(pre, comp));
      $display("test pass with divisor %0d done", dv[k]);
    end
    // corner cases: divisor beyond range folds down, disable clears fault
    apb(1'b1, CTRL_OFS, 32'h1f);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(q, {26'h0, 1'b1, DIV_MAX, 1'b1});
    comp <= pre ^ bad;
    apb(1'b1, CTRL_OFS, 32'h1);
    wait_done(n);
    wait_done(n);
    chk(32'(flt), 32'h1);
    apb(1'b1, CTRL_OFS, 32'h0);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(32'(q[1:0]), 32'h0);
    chk(32'(flt), 32'h0);
    chk(32'(pin.oe_b), 32'h1);
    $display("test clamp and disable done");
    results();
  end
  initial
  begin
    repeat (80000) @(posedge clk);
    fails++;
    results();
  end
endmodule

// [src/crcsr_pkg.sv]
// constants and types shared by the crc signature readout port
package crcsr_pkg;
  // ==========================================================
  // register map (byte addresses, one 32-bit word each)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PRECRC_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] SIG_OFS = 8'h0c;
  // ==========================================================
  // control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DIV_LSB = 1;
  localparam int CTRL_DIV_W = 4;
  localparam int CTRL_OD_BIT = 5;
  localparam logic [3:0] DIV_MAX = 4'h8;
  // status fields
  localparam int STAT_FAULT_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  localparam int STAT_PASS_LSB = 8;
  // ==========================================================
  // reset values
  localparam logic CTRL_EN_RST = 1'b0;
  localparam logic [3:0] CTRL_DIV_RST = 4'h0;
  localparam logic CTRL_OD_RST = 1'b0;
  localparam logic [31:0] PRECRC_RST = 32'h0000_0000;
  localparam logic [31:0] SIG_RST = 32'h0000_0000;
  // ==========================================================
  // timing: detection clock ticks in one checking pass
  localparam logic [15:0] PASS_TICKS = 16'h0040;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    CRCSR_IDLE = 2'b00,
    CRCSR_RUN = 2'b01
  } crcsr_state_t;
  typedef struct packed {
    logic rclk;
    logic shift_nld;
    logic ld_src;
  } crcsr_rd_t;
  typedef struct packed {
    logic drv;
    logic oe_b;
  } crcsr_pin_t;
endpackage

// [src/crcsr_top.sv]
// crc signature readout port with detection clock divider and apb registers
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/10ps
module crcsr_top
#(
  parameter bit FORCE_OD = 1'b0
)
(
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire crcsr_pkg::crcsr_rd_t rd_in,
  input wire logic [31:0] computed_crc_in,
  output logic regout_out,
  output logic crc_fault_out,
  output crcsr_pkg::crcsr_pin_t fault_pin_out,
  output logic cycle_done_out
);
  import crcsr_pkg::*;

  // ==========================================================
  // state, grouped as the processes below are: register bus, readout
  // shifter, divider, detection passes and error pin
  logic en_r, en_nxt;
  logic [3:0] div_r, div_nxt;
  logic od_r, od_nxt;
  logic [31:0] precrc_r, precrc_nxt;
  logic [31:0] sig_r, sig_nxt;
  logic [31:0] shreg_r, shreg_nxt;
  logic rclk_q_r, rclk_q_nxt;
  logic regout_r, regout_nxt;
  logic [7:0] divcnt_r, divcnt_nxt;
  logic [15:0] tickcnt_r, tickcnt_nxt;
  logic [23:0] passes_r, passes_nxt;
  logic fault_r, fault_nxt;
  logic done_r, done_nxt;
  crcsr_pin_t pin_r, pin_nxt;
  crcsr_state_t st_r, st_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic tick;
  logic wr_acc;
  logic hit;
  logic od_eff;

  // divider exponent limited to the largest legal power; larger requests
  // are folded down rather than refused, so checking never stops
  function automatic logic [3:0] clamp_div(input logic [3:0] n);
    return (n > DIV_MAX) ? DIV_MAX : n;
  endfunction

  // mask of low divider bits for 2**n, n clamped to 8
  function automatic logic [7:0] div_mask(input logic [3:0] n);
    logic [8:0] full;
    full = (9'h001 << clamp_div(n)) - 9'h001;
    return full[7:0];
  endfunction

  // decode the four register offsets
  function automatic logic reg_hit(input logic [7:0] a);
    return (a == CTRL_OFS) || (a == PRECRC_OFS) || (a == STATUS_OFS) || (a == SIG_OFS);
  endfunction

  assign od_eff = FORCE_OD | od_r;
  assign tick = ((divcnt_r & div_mask(div_r)) == div_mask(div_r));
  assign hit = reg_hit(paddr_in);
  assign wr_acc = psel_in & penable_in & pready_r & pwrite_in & hit;

  // ==========================================================
  // register bus group: control, precomputed value and the read port
  // read data is latched at setup and shown during the access cycle
  always_comb
  begin
    en_nxt = en_r;
    div_nxt = div_r;
    od_nxt = od_r;
    precrc_nxt = precrc_r;
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;

    // apb: answer in the cycle after setup, zero wait states
    if (psel_in && !penable_in)
    begin
      pready_nxt = 1'b1;
      pslverr_nxt = ~hit;
      prdata_nxt = 32'h0000_0000;
      case (paddr_in)
        CTRL_OFS: prdata_nxt = {26'h0, od_eff, div_r, en_r};
        PRECRC_OFS: prdata_nxt = precrc_r;
        STATUS_OFS: prdata_nxt = {passes_r, 6'h0, (st_r == CRCSR_RUN), fault_r};
        SIG_OFS: prdata_nxt = sig_r;
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
    if (wr_acc)
    begin
      case (paddr_in)
        CTRL_OFS:
        begin
          en_nxt = pwdata_in[CTRL_EN_BIT];
          div_nxt = clamp_div(pwdata_in[CTRL_DIV_LSB +: CTRL_DIV_W]);
          od_nxt = pwdata_in[CTRL_OD_BIT];
        end
        PRECRC_OFS: precrc_nxt = pwdata_in;
        default: precrc_nxt = precrc_r;
      endcase
    end
  end

  // register bus flops; reset leaves detection switched off
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      en_r <= CTRL_EN_RST;
      div_r <= CTRL_DIV_RST;
      od_r <= CTRL_OD_RST;
      precrc_r <= PRECRC_RST;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      en_r <= en_nxt;
      div_r <= div_nxt;
      od_r <= od_nxt;
      precrc_r <= precrc_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ==========================================================
  // readout group: the user clock is sampled, never used as a clock, so
  // the shifter stays in the oscillator domain; the user clock must stay
  // high and low for a full system cycle each, or edges are lost
  always_comb
  begin
    shreg_nxt = shreg_r;
    regout_nxt = regout_r;
    rclk_q_nxt = rd_in.rclk;

    // readout shifter acts only on a rising readout clock edge
    if (rd_in.rclk && !rclk_q_r)
    begin
      if (rd_in.shift_nld)
      begin
        shreg_nxt = {1'b0, shreg_r[31:1]};
        regout_nxt = shreg_r[1];
      end
      else
      begin
        shreg_nxt = rd_in.ld_src ? sig_r : precrc_r;
        regout_nxt = rd_in.ld_src ? sig_r[0] : precrc_r[0];
      end
    end
  end

  // readout flops; the detector starts low, so a user clock that is
  // already high when reset ends is taken as one rising edge
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      shreg_r <= 32'h0000_0000;
      regout_r <= 1'b0;
      rclk_q_r <= 1'b0;
    end
    else
    begin
      shreg_r <= shreg_nxt;
      regout_r <= regout_nxt;
      rclk_q_r <= rclk_q_nxt;
    end
  end

  // ==========================================================
  // divider group: free-running count of oscillator cycles; the count is
  // not restarted on a divisor change, so the first tick after it may
  // come early
  always_comb
  begin
    divcnt_nxt = tick ? 8'h00 : divcnt_r + 8'h01;
  end

  // divider flops
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      divcnt_r <= 8'h00;
    end
    else
    begin
      divcnt_r <= divcnt_nxt;
    end
  end

  // ==========================================================
  // detection group: passes paced by detection ticks; signature, fault
  // and, only with FORCE_OD set, the completion pulse all change on the same
  // pass-end edge, so a reader never sees a fault without the signature that explains it
  always_comb
  begin
    tickcnt_nxt = tickcnt_r;
    passes_nxt = passes_r;
    fault_nxt = fault_r;
    done_nxt = 1'b0;
    sig_nxt = sig_r;
    st_nxt = st_r;

    // checking passes, paced by detection ticks
    case (st_r)
      CRCSR_IDLE:
      begin
        // pass counter restarts so the first pass is full length
        tickcnt_nxt = 16'h0000;
        if (en_r)
          st_nxt = CRCSR_RUN;
      end
      CRCSR_RUN:
      begin
        // enable cleared mid-pass: the cut pass is dropped, fault cleared
        if (!en_r)
        begin
          st_nxt = CRCSR_IDLE;
          fault_nxt = 1'b0;
        end
        else if (tick)
        begin
          if (tickcnt_r == PASS_TICKS - 16'h0001)
          begin
            tickcnt_nxt = 16'h0000;
            sig_nxt = computed_crc_in ^ precrc_r;
            fault_nxt = (computed_crc_in != precrc_r);
            done_nxt = FORCE_OD;
            passes_nxt = passes_r + 24'h000001;
          end
          else
            tickcnt_nxt = tickcnt_r + 16'h0001;
        end
      end
      default: st_nxt = CRCSR_IDLE;
    endcase
  end

  // detection flops
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      sig_r <= SIG_RST;
      tickcnt_r <= 16'h0000;
      passes_r <= 24'h000000;
      fault_r <= 1'b0;
      done_r <= 1'b0;
      st_r <= CRCSR_IDLE;
    end
    else
    begin
      sig_r <= sig_nxt;
      tickcnt_r <= tickcnt_nxt;
      passes_r <= passes_nxt;
      fault_r <= fault_nxt;
      done_r <= done_nxt;
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // pin group: follows the next fault value so pin and fault flop
  // change on the same edge and never disagree for a cycle
  always_comb
  begin
    pin_nxt = pin_r;

    // error pin: open-drain releases for high, push-pull drives both
    if (!en_r)
    begin
      pin_nxt.drv = 1'b0;
      pin_nxt.oe_b = 1'b1;
    end
    else if (od_eff)
    begin
      pin_nxt.drv = 1'b0;
      pin_nxt.oe_b = fault_nxt;
    end
    else
    begin
      pin_nxt.drv = fault_nxt;
      pin_nxt.oe_b = 1'b0;
    end
  end

  // pin flops; reset releases the pin so nothing is driven before enable
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      pin_r <= '{drv: 1'b0, oe_b: 1'b1};
    end
    else
    begin
      pin_r <= pin_nxt;
    end
  end

  // outputs straight from flip-flops; fault timed by oscillator only
  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign regout_out = regout_r;
  assign crc_fault_out = fault_r;
  assign fault_pin_out = pin_r;
  assign cycle_done_out = done_r;
endmodule
